// *** logic/synth_divider_calibration_ctrl.sv ***
// Purpose: post-divider decode, calibration sequencer and lock detector
// Assumes: pfd tick and feedback tick are pin inputs from the analog loop
// Notes:   staged registers become active only on an update write
// Overview of the data path
// The register file is split in two copies. The staged copy takes every
// bus write at once and is what a read of the 0x1xx page returns. The
// active copy loads from the staged copy only on a valid update write,
// and only the active copy steers the dividers, the loop mode and the
// sequencer. Software can therefore build a whole new setting over many
// writes and apply it in one clock, which keeps the two post-dividers
// and the loop mode from ever being seen half changed.
//
// The pfd and feedback ticks, the reference missing flag and the preset
// done flag come from other clock domains. Each passes three flops, and
// a filtered level moves only when the second and third stages agree.
// The cost is that a tick must stay at one level for at least two system
// clocks to be seen; faster pfd rates must be divided down before here.
//
// The calibration sequencer has three states. It idles until a request
// is pending, waits for a usable reference, then counts pfd edges for
// the whole calibration. While it is not idle both post-dividers sit in
// synchronous reset, so a manual divider reset is never needed after a
// calibration. A request that arrives while one runs is queued, so a
// software recalibration is never lost behind a preset calibration.
//
// Limitations a user must know:
// - the total feedback division is a plain level and is not
//   synchronised; it must be static while a calibration waits.
// - the lock detector only counts edges; it reports frequency lock,
//   never phase alignment.
// - the channel hold is released only at the end of the first
//   calibration after a chip or loop reset; later calibrations leave
//   the distribution running.
//
// Decided for this implementation: strobed register access.
module synth_divider_calibration_ctrl
  import synth_ctrl_pkg::*;
(
  input  wire logic        SYS_CLK_I,       // 100 MHz system clock
  input  wire logic        NRST_I,          // synchronous reset, active low
  input  wire logic        LOOP_NRST_I,     // loop reset, active low
  input  wire logic [11:0] ADDR_I,          // register address
  input  wire logic [7:0]  WDATA_I,         // write data
  input  wire logic        WR_I,            // write strobe
  input  wire logic        RD_I,            // read strobe
  output logic      [7:0]  RDATA_O,         // read data, cycle after strobe
  input  wire logic        PFD_TICK_I,      // reference at pfd, pin
  input  wire logic        FB_TICK_I,       // feedback at pfd, pin
  input  wire logic        REF_MISSING_I,   // reference missing flag, pin
  input  wire logic        PRESET_DONE_I,   // pin-strap preset load done
  input  wire logic [15:0] FB_TOTAL_I,      // total feedback division
  output postdiv_t         DIV_A_O,         // post_divider_a control
  output postdiv_t         DIV_B_O,         // post_divider_b control
  output logic      [3:0]  CHAN_SRC_A_O,    // channels zero..three on a
  output logic             ZD_SRC_A_O,      // zero-delay div on a
  output logic      [3:0]  CHAN_SRC_B_O,    // channels clockable from b
  output logic             CHAN_HOLD_O,     // channels held, outputs static
  output logic      [1:0]  LOOP_ACTIVE_O,   // loop mode applied to analog
  output logic             LOCK_O           // lock detect result
);
  localparam int CAL_W = 17;
  localparam logic [CAL_W-1:0] CAL_LAST  = CAL_W'(CAL_PFD_CYCLES - 1);
  localparam logic [CAL_W-1:0] LOCK_LAST = CAL_W'(LOCK_PFD_CYCLES - 1);
  // lock window: 16 ppm of 65,500 is about one cycle
  localparam logic [CAL_W-1:0] LOCK_TOL  = CAL_W'(1);

  // staged and active registers
  logic [7:0] control_q, loopmode_q, fbint_q, divrst_q, ratios_q;
  logic [7:0] control_a_q, loopmode_a_q, fbint_a_q, divrst_a_q, ratios_a_q;
  logic       commit;
  logic       cal_req_prev_q;
  cal_state_t cal_st_q;
  logic [CAL_W-1:0] cal_cnt_q;
  logic       first_cal_q;
  logic       preset_prev_q;

  // three-stage synchronisers; change counts when stages two and three agree
  logic [2:0] pfd_s_q, fb_s_q, lor_s_q, pre_s_q;
  logic       pfd_f_q, fb_f_q, lor_f_q, pre_f_q;
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      pfd_s_q <= 3'h0;
      fb_s_q  <= 3'h0;
      lor_s_q <= 3'h7;
      pre_s_q <= 3'h0;
    end else begin
      pfd_s_q <= {pfd_s_q[1:0], PFD_TICK_I};
      fb_s_q  <= {fb_s_q[1:0], FB_TICK_I};
      lor_s_q <= {lor_s_q[1:0], REF_MISSING_I};
      pre_s_q <= {pre_s_q[1:0], PRESET_DONE_I};
    end
  end

  // filtered levels follow only once stages two and three agree
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      pfd_f_q <= 1'b0;
      fb_f_q  <= 1'b0;
      lor_f_q <= 1'b1;
      pre_f_q <= 1'b0;
    end else begin
      if (pfd_s_q[1] == pfd_s_q[2]) pfd_f_q <= pfd_s_q[2];
      if (fb_s_q[1] == fb_s_q[2])   fb_f_q  <= fb_s_q[2];
      if (lor_s_q[1] == lor_s_q[2]) lor_f_q <= lor_s_q[2];
      if (pre_s_q[1] == pre_s_q[2]) pre_f_q <= pre_s_q[2];
    end
  end

  // rising edges of the pfd and feedback clocks
  logic pfd_prev_q, fb_prev_q, pfd_rise, fb_rise;
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      pfd_prev_q <= 1'b0;
      fb_prev_q  <= 1'b0;
    end else begin
      pfd_prev_q <= pfd_f_q;
      fb_prev_q  <= fb_f_q;
    end
  end
  assign pfd_rise = pfd_f_q & ~pfd_prev_q;
  assign fb_rise  = fb_f_q & ~fb_prev_q;

  // staged register writes
  assign commit = WR_I && (ADDR_I == OFS_UPDATE) &&
                  (WDATA_I == UPDATE_CODE);
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      control_q  <= CONTROL_RST;
      loopmode_q <= LOOPMODE_RST;
      fbint_q    <= FBINT_RST;
      divrst_q   <= DIVRST_RST;
      ratios_q   <= RATIOS_RST;
    end else if (WR_I) begin
      unique case (ADDR_I)
        OFS_CONTROL:  control_q  <= WDATA_I;
        OFS_LOOPMODE: loopmode_q <= WDATA_I;
        OFS_FBINT:    fbint_q    <= WDATA_I;
        OFS_DIVRST:   divrst_q   <= WDATA_I;
        OFS_RATIOS:   ratios_q   <= WDATA_I;
        default: ;
      endcase
    end
  end

  // active copies load only on an update commit
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      control_a_q  <= CONTROL_RST;
      loopmode_a_q <= LOOPMODE_RST;
      fbint_a_q    <= FBINT_RST;
      divrst_a_q   <= DIVRST_RST;
      ratios_a_q   <= RATIOS_RST;
    end else if (commit) begin
      control_a_q  <= control_q;
      loopmode_a_q <= loopmode_q;
      fbint_a_q    <= fbint_q;
      divrst_a_q   <= divrst_q;
      ratios_a_q   <= ratios_q;
    end
  end

  // calibration request: committed rising edge or preset completion
  logic cal_bit, manual_req, preset_req, cal_pending_q, ref_ok;
  logic [1:0] loop_sel;
  assign cal_bit    = control_a_q[CTRL_CAL_BIT];
  assign manual_req = cal_bit & ~cal_req_prev_q;
  assign preset_req = pre_f_q & ~preset_prev_q;
  assign loop_sel   = loopmode_a_q[LOOP_LSB +: 2];
  // low reference rates in loop one fall below the flag's threshold
  assign ref_ok = ((loop_sel == LOOP_MODE_ONE) &&
                   (FB_TOTAL_I >= LOR_BYPASS_N)) ? pfd_rise
                                                 : ~lor_f_q;

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      cal_req_prev_q <= 1'b0;
      preset_prev_q  <= 1'b0;
    end else begin
      cal_req_prev_q <= cal_bit;
      preset_prev_q  <= pre_f_q;
    end
  end

  // a request that arrives during a running calibration is kept pending
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      cal_pending_q <= 1'b0;
    end else if (manual_req || preset_req) begin
      cal_pending_q <= 1'b1;
    end else if (cal_st_q == CAL_IDLE) begin
      cal_pending_q <= 1'b0;
    end
  end

  // calibration sequencer
  // the counter runs on pfd edges, not system clocks, so the calibration
  // time scales with the pfd rate; the count is cleared in idle so that a
  // queued request always starts from zero. leaving wait_ref needs only a
  // clear flag, or in loop one with a long feedback chain a single pfd
  // edge, because the flag cannot see very slow references there.
  // an unused fourth state code cannot be reached from reset, so no
  // default branch is given.
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      cal_st_q  <= CAL_IDLE;
      cal_cnt_q <= '0;
    end else begin
      unique case (cal_st_q)
        CAL_IDLE: begin
          cal_cnt_q <= '0;
          if (cal_pending_q) cal_st_q <= CAL_WAIT_REF;
        end
        CAL_WAIT_REF: begin
          if (ref_ok) cal_st_q <= CAL_RUN;
        end
        CAL_RUN: begin
          if (pfd_rise) begin
            if (cal_cnt_q == CAL_LAST) begin
              cal_st_q  <= CAL_IDLE;
            end else begin
              cal_cnt_q <= cal_cnt_q + CAL_W'(1);
            end
          end
        end
      endcase
    end
  end

  // first calibration after chip or loop reset holds the distribution
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I || !LOOP_NRST_I) begin
      first_cal_q <= 1'b1;
    end else if (cal_st_q == CAL_RUN && pfd_rise &&
                 cal_cnt_q == CAL_LAST) begin
      first_cal_q <= 1'b0;
    end
  end

  logic cal_busy;
  assign cal_busy = (cal_st_q != CAL_IDLE);

  // post-divider decode; out-of-range codes power the divider down
  logic [3:0] ratio_a, ratio_b;
  logic       run_a, run_b;
  assign ratio_a = ratios_a_q[3:0];
  assign ratio_b = ratios_a_q[7:4];
  assign run_a   = (ratio_a >= RATIO_MIN) && (ratio_a <= RATIO_MAX);
  assign run_b   = (ratio_b >= RATIO_MIN) && (ratio_b <= RATIO_MAX);

  // registered outputs
  // all control outputs are flopped so that the analog side sees one
  // clean change per commit, never the glitches of the decode; the price
  // is one clock of latency after the active registers move. powered
  // down dividers also show a zero ratio so nothing downstream can read
  // a stale divide value.
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      DIV_A_O       <= '0;
      DIV_B_O       <= '0;
      CHAN_SRC_A_O  <= 4'h0;
      ZD_SRC_A_O    <= 1'b0;
      CHAN_SRC_B_O  <= 4'h0;
      CHAN_HOLD_O   <= 1'b1;
      LOOP_ACTIVE_O <= 2'h0;
    end else begin
      DIV_A_O.run   <= run_a;
      DIV_A_O.ratio <= run_a ? ratio_a : 4'h0;
      // calibration reset dominates the held software reset
      DIV_A_O.srst  <= cal_busy | divrst_a_q[RST_A_BIT];
      DIV_B_O.run   <= run_b;
      DIV_B_O.ratio <= run_b ? ratio_b : 4'h0;
      DIV_B_O.srst  <= cal_busy | divrst_a_q[RST_B_BIT];
      CHAN_SRC_A_O  <= {4{run_a}};
      ZD_SRC_A_O    <= run_a;
      CHAN_SRC_B_O  <= {1'b0, run_b, run_b, 1'b0};
      CHAN_HOLD_O   <= first_cal_q;
      // loop two feedback stops during calibration, so use loop zero
      LOOP_ACTIVE_O <= (cal_busy && loop_sel == LOOP_MODE_TWO) ?
                       2'h0 : loop_sel;
    end
  end

  // lock detector: count feedback edges over a window of pfd edges
  // the window is a fixed number of pfd edges; at its end the feedback
  // count is compared with that number less one, and a difference of at most
  // one count is taken as lock. a feedback edge in the closing cycle is
  // carried into the next window so that no edge is dropped. the
  // detector is held cleared while calibrating, because the loop is
  // opened then and any result would be meaningless; a loop reset also
  // clears it so that a stale lock never survives a restart.
  logic [CAL_W-1:0] ld_win_q, ld_fb_q;
  logic [CAL_W-1:0] ld_diff;
  assign ld_diff = (ld_fb_q > LOCK_LAST) ? (ld_fb_q - LOCK_LAST)
                                         : (LOCK_LAST - ld_fb_q);
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I || !LOOP_NRST_I || cal_busy) begin
      ld_win_q <= '0;
      ld_fb_q  <= '0;
      LOCK_O   <= 1'b0;
    end else begin
      if (pfd_rise && ld_win_q == LOCK_LAST) begin
        LOCK_O   <= (ld_diff <= LOCK_TOL);
        ld_win_q <= '0;
        ld_fb_q  <= fb_rise ? CAL_W'(1) : '0;
      end else begin
        if (pfd_rise) ld_win_q <= ld_win_q + CAL_W'(1);
        if (fb_rise)  ld_fb_q  <= ld_fb_q + CAL_W'(1);
      end
    end
  end

  // status readback; unmapped and write-only addresses read zero
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      unique case (ADDR_I)
        OFS_STATUS:   RDATA_O <= {5'h00, cal_busy, 1'b0, LOCK_O};
        OFS_CONTROL:  RDATA_O <= control_q;
        OFS_LOOPMODE: RDATA_O <= loopmode_q;
        OFS_FBINT:    RDATA_O <= fbint_q;
        OFS_DIVRST:   RDATA_O <= divrst_q;
        OFS_RATIOS:   RDATA_O <= ratios_q;
        default:      RDATA_O <= 8'h00;
      endcase
    end else begin
      RDATA_O <= 8'h00;
    end
  end
endmodule // synth_divider_calibration_ctrl

// *** shared/synth_ctrl_pkg.sv ***
// Purpose: constants and types for the synthesizer divider/calibration block
// Assumes: 8-bit registers at their printed offsets, one system clock
// Notes:   pfd and feedback events arrive as pins and are synchronised
package synth_ctrl_pkg;
  localparam logic [11:0] OFS_UPDATE   = 12'h00F;
  localparam logic [11:0] OFS_STATUS   = 12'h020;
  localparam logic [11:0] OFS_CONTROL  = 12'h100;
  localparam logic [11:0] OFS_LOOPMODE = 12'h101;
  localparam logic [11:0] OFS_FBINT    = 12'h107;
  localparam logic [11:0] OFS_DIVRST   = 12'h120;
  localparam logic [11:0] OFS_RATIOS   = 12'h121;
  localparam logic [7:0]  UPDATE_CODE  = 8'h01;
  // field positions
  localparam int CTRL_CAL_BIT   = 3;
  localparam int STAT_CAL_BIT   = 2;
  localparam int STAT_LOCK_BIT  = 0;
  localparam int LOOP_LSB       = 1;
  localparam int RST_A_BIT      = 0;
  localparam int RST_B_BIT      = 4;
  // reset values
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] LOOPMODE_RST = 8'h00;
  localparam logic [7:0] FBINT_RST    = 8'h00;
  localparam logic [7:0] DIVRST_RST   = 8'h00;
  localparam logic [7:0] RATIOS_RST   = 8'h00;
  // ratio decode bounds and gating threshold
  localparam logic [3:0]  RATIO_MIN    = 4'h2;
  localparam logic [3:0]  RATIO_MAX    = 4'hB;
  localparam logic [15:0] LOR_BYPASS_N = 16'h0200;
  // timing counts in pfd cycles
  localparam int CAL_PFD_CYCLES  = 98500;
  localparam int LOCK_PFD_CYCLES = 65500;
  localparam logic [1:0] LOOP_MODE_ONE = 2'h1;
  localparam logic [1:0] LOOP_MODE_TWO = 2'h2;

  typedef struct packed {
    logic        run;     // post-divider running
    logic [3:0]  ratio;   // divide value when running
    logic        srst;    // synchronous reset applied
  } postdiv_t;

  typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT_REF, CAL_RUN} cal_state_t;
endpackage

// *** verif/synth_ctrl_chk_sva.sv ***
// Purpose: port-level checker for the divider/calibration controller
// Assumes: one clock, synchronous active-low chip reset
// Notes:   commit window tolerates one cycle of latency either way
module synth_ctrl_chk
  import synth_ctrl_pkg::*;
(
  input wire logic        SYS_CLK_I,     // system clock
  input wire logic        NRST_I,        // chip reset, active low
  input wire logic        LOOP_NRST_I,   // loop reset, active low
  input wire logic [11:0] ADDR_I,        // register address
  input wire logic [7:0]  WDATA_I,       // write data
  input wire logic        WR_I,          // write strobe
  input wire logic        RD_I,          // read strobe
  input wire logic [7:0]  RDATA_O,       // read data
  input wire postdiv_t    DIV_A_O,       // divider a control
  input wire postdiv_t    DIV_B_O,       // divider b control
  input wire logic [3:0]  CHAN_SRC_A_O,  // channels on a
  input wire logic        ZD_SRC_A_O,    // zero-delay on a
  input wire logic [3:0]  CHAN_SRC_B_O,  // channels on b
  input wire logic        LOCK_O         // lock result
);
  logic [2:0] upd_q;  // recent update commits, oldest on top
  logic       upd_d;

  // valid commit writes seen on the bus
  assign upd_d = WR_I && ADDR_I == OFS_UPDATE && WDATA_I == UPDATE_CODE;
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) upd_q <= 3'h0;
    else upd_q <= {upd_q[1:0], upd_d};
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);

  // reads below the 0x100 page, status excepted, hold no data
  sequence low_rd_s; RD_I && ADDR_I[11:8] == 4'h0 && ADDR_I != OFS_STATUS;
  endsequence
  sequence lrst_s; !LOOP_NRST_I ##1 !LOOP_NRST_I; endsequence

  rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data outside its cycle");
  low_page_a: assert property (low_rd_s |=> RDATA_O == 8'h00)
    else $error("refused read returned data");
  ratio_a_a: assert property (DIV_A_O.run |-> DIV_A_O.ratio inside
    {[RATIO_MIN:RATIO_MAX]}) else $error("divider a bad ratio");
  ratio_b_a: assert property (DIV_B_O.run |-> DIV_B_O.ratio inside
    {[RATIO_MIN:RATIO_MAX]}) else $error("divider b bad ratio");
  off_zero_a: assert property (!DIV_A_O.run |-> DIV_A_O.ratio == 4'h0)
    else $error("stopped divider keeps ratio");
  src_a_a: assert property (CHAN_SRC_A_O == {4{DIV_A_O.run}} &&
    ZD_SRC_A_O == DIV_A_O.run) else $error("divider a fan-out");
  src_b_a: assert property (CHAN_SRC_B_O == {1'b0, {2{DIV_B_O.run}}, 1'b0})
    else $error("divider b fan-out");
  commit_only_a: assert property ($changed({DIV_A_O.ratio, DIV_B_O.ratio})
    |-> |upd_q) else $error("ratio moved without commit");
  lock_clear_a: assert property (lrst_s |=> !LOCK_O)
    else $error("lock kept through loop reset");
endmodule // synth_ctrl_chk

bind synth_divider_calibration_ctrl synth_ctrl_chk u_chk (
  .SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .LOOP_NRST_I(LOOP_NRST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .DIV_A_O(DIV_A_O), .DIV_B_O(DIV_B_O),
  .CHAN_SRC_A_O(CHAN_SRC_A_O), .ZD_SRC_A_O(ZD_SRC_A_O),
  .CHAN_SRC_B_O(CHAN_SRC_B_O), .LOCK_O(LOCK_O));

// *** verif/synth_divider_calibration_ctrl_tb.sv ***
// Purpose: self-checking bench for the divider/calibration controller
// Assumes: pfd and feedback ticks share one pin level, period four clocks
// Notes:   one full calibration runs, so the run is long but bounded
module synth_divider_calibration_ctrl_tb;
  import synth_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // the pin filter needs two stable samples, so one pfd edge per 4 clocks
  localparam int CAL_CLKS = 4 * CAL_PFD_CYCLES;
  logic [1:0]  tk;
  logic        clk, nrst, lnrst, wr, rd, pfd, ref_miss, preset, zd, hold;
  logic        lock;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata, d;
  logic [3:0]  csa, csb;
  logic [1:0]  loopa;
  postdiv_t    da, db;
  int          failures, num_checks, n;
  // ratio byte beside expected run of divider a and b
  logic [9:0]  rows [6] = '{{8'h10, 2'b00}, {8'h2B, 2'b11}, {8'hC1, 2'b00},
                            {8'h5F, 2'b01}, {8'hB2, 2'b11}, {8'h37, 2'b11}};

  synth_divider_calibration_ctrl dut (
    .SYS_CLK_I(clk), .NRST_I(nrst), .LOOP_NRST_I(lnrst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .PFD_TICK_I(pfd), .FB_TICK_I(pfd), .REF_MISSING_I(ref_miss),
    .PRESET_DONE_I(preset), .FB_TOTAL_I(16'h0000), .DIV_A_O(da),
    .DIV_B_O(db), .CHAN_SRC_A_O(csa), .ZD_SRC_A_O(zd), .CHAN_SRC_B_O(csb),
    .CHAN_HOLD_O(hold), .LOOP_ACTIVE_O(loopa), .LOCK_O(lock));

  // clock and a free-running pfd tick
  always #5 clk = ~clk;
  always @(posedge clk) tk <= tk + 2'h1;
  assign pfd = tk[1];

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle strobes with an idle cycle after, so no strobe is set twice
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [7:0] v);
    addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic commit();
    wr_reg(OFS_UPDATE, UPDATE_CODE);
    repeat (4) @(posedge clk);
  endtask

  task automatic give_verdict();
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog sized for one calibration plus margin
  initial begin
    repeat (CAL_CLKS + 40000) @(posedge clk);
    failures++;
    give_verdict();
  end

  initial begin
    clk = 0; tk = 2'h0; nrst = 0; lnrst = 1; wr = 0; rd = 0; addr = 0;
    wdata = 0; ref_miss = 1; preset = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("hold_at_reset", hold, 1'b1);
    // decode table, boundaries 0,1,2,11,15 on field a and 1,2,11,12 on field b
    foreach (rows[i]) begin
      wr_reg(OFS_RATIOS, rows[i][9:2]);
      commit();
      chk("run_a", da.run, rows[i][1]);
      chk("run_b", db.run, rows[i][0]);
      chk("ratio_a", da.ratio, rows[i][1] ? rows[i][5:2] : 4'h0);
      chk("ratio_b", db.ratio, rows[i][0] ? rows[i][9:6] : 4'h0);
      chk("src_a", {csa, zd}, {5{rows[i][1]}});
      chk("src_b", csb, {1'b0, {2{rows[i][0]}}, 1'b0});
    end
    // a wrong update code leaves the active ratio alone
    wr_reg(OFS_RATIOS, 8'h44);
    wr_reg(OFS_UPDATE, 8'h02);
    repeat (4) @(posedge clk);
    chk("ratio_kept", da.ratio, 4'h7);
    rd_reg(OFS_RATIOS, d); chk("staged", d, 8'h44);
    rd_reg(12'h0FF, d); chk("unmapped", d, 8'h00);
    rd_reg(OFS_UPDATE, d); chk("upd_read", d, 8'h00);
    // manual divider resets held while committed, both, one then neither
    foreach (rows[i]) if (i < 3) begin
      wr_reg(OFS_DIVRST, i == 0 ? 8'h11 : (i == 1 ? 8'h01 : 8'h00));
      commit();
      chk("srst_a", da.srst, i < 2);
      chk("srst_b", db.srst, i == 0);
    end
    // first calibration in loop two, reference missing at first
    wr_reg(OFS_FBINT, 8'h32);
    wr_reg(OFS_LOOPMODE, 8'h04);
    wr_reg(OFS_CONTROL, 8'h08);
    commit();
    rd_reg(OFS_STATUS, d); chk("busy", d[STAT_CAL_BIT], 1'b1);
    chk("cal_srst", {da.srst, db.srst}, 2'b11);
    chk("cal_hold", hold, 1'b1);
    chk("cal_loop", loopa, 2'h0);
    repeat (2000) @(posedge clk);
    rd_reg(OFS_STATUS, d); chk("ref_wait", d[STAT_CAL_BIT], 1'b1);
    ref_miss <= 1'b0;
    n = 0;
    while (hold !== 1'b0 && n < CAL_CLKS + 20000) begin
      @(posedge clk);
      n++;
    end
    chk("cal_len", n > CAL_CLKS - 60 && n < CAL_CLKS + 60, 1'b1);
    repeat (4) @(posedge clk);
    rd_reg(OFS_STATUS, d); chk("done", d[STAT_CAL_BIT], 1'b0);
    chk("loop_back", loopa, LOOP_MODE_TWO);
    chk("srst_off", {da.srst, db.srst}, 2'b00);
    // a bit left at one starts nothing
    commit();
    rd_reg(OFS_STATUS, d); chk("no_retrig", d[STAT_CAL_BIT], 1'b0);
    // loop reset clears lock, then a preset load launches calibration
    lnrst <= 1'b0;
    repeat (3) @(posedge clk);
    lnrst <= 1'b1;
    chk("lock_clr", lock, 1'b0);
    preset <= 1'b1;
    repeat (10) @(posedge clk);
    rd_reg(OFS_STATUS, d); chk("preset_cal", d[STAT_CAL_BIT], 1'b1);
    // forced loop-one recalibration, queued behind the running one
    wr_reg(OFS_CONTROL, 8'h00);
    wr_reg(OFS_LOOPMODE, 8'h02);
    commit();
    wr_reg(OFS_FBINT, 8'h32);
    wr_reg(OFS_CONTROL, 8'h08);
    commit();
    rd_reg(OFS_STATUS, d); chk("queued_cal", d[STAT_CAL_BIT], 1'b1);
    chk("loop_one", loopa, LOOP_MODE_ONE);
    // chip reset in mid-calibration
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    chk("rst_hold", hold, 1'b1);
    chk("rst_div", {da, db}, 12'h000);
    give_verdict();
  end
endmodule // synth_divider_calibration_ctrl_tb
